// File: hw/smsp_pkg.sv
// Purpose: constants, types and helpers of the serial port block
// Assumes: 25 MHz hclk, AHB-Lite register access, 8-bit frames
// Notes:   register index times four gives the AHB byte address
`default_nettype none

package smsp_pkg;

  localparam int          BUS_W     = 32;
  localparam int          DEC_W     = 10;
  // register indices; byte address is index times four
  localparam logic [7:0]  IDX_CTRL  = 8'h2c;
  localparam logic [7:0]  IDX_STAT  = 8'h2d;
  localparam logic [7:0]  IDX_DATA  = 8'h2e;
  localparam logic [DEC_W-1:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [DEC_W-1:0] ADDR_STAT = {IDX_STAT, 2'b00};
  localparam logic [DEC_W-1:0] ADDR_DATA = {IDX_DATA, 2'b00};

  // control register fields
  localparam int          C_IRQ_EN  = 7;
  localparam int          C_PORT_EN = 6;
  localparam int          C_LSB     = 5;
  localparam int          C_MASTER_SELECT    = 4;
  localparam int          C_CLOCK_POLARITY    = 3;
  localparam int          C_CLOCK_PHASE    = 2;
  localparam int          C_RATE_HI = 1;
  localparam int          C_RATE_LO = 0;
  localparam logic [7:0]  CTRL_RST  = 8'h00;

  // status register fields
  localparam int          S_TC      = 7;
  localparam int          S_WRITE_COLLISION_FLAG    = 6;
  localparam int          S_DBL     = 0;

  localparam logic [3:0]  EDGE_LAST = 4'hf;
  localparam logic [3:0]  EDGE_ZERO = 4'h0;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;

  // half serial-clock periods in hclk cycles
  localparam logic [6:0]  HALF_2    = 7'h01;
  localparam logic [6:0]  HALF_4    = 7'h02;
  localparam logic [6:0]  HALF_8    = 7'h04;
  localparam logic [6:0]  HALF_16   = 7'h08;
  localparam logic [6:0]  HALF_32   = 7'h10;
  localparam logic [6:0]  HALF_64   = 7'h20;
  localparam logic [6:0]  HALF_128  = 7'h40;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } smsp_state_t;

  function automatic logic [6:0] half_cycles(input logic       dbl,
                                             input logic [1:0] rate);
    logic [6:0] h;
    h = HALF_4;
    case ({dbl, rate})
      3'b000:  h = HALF_4;
      3'b001:  h = HALF_16;
      3'b010:  h = HALF_64;
      3'b011:  h = HALF_128;
      3'b100:  h = HALF_2;
      3'b101:  h = HALF_8;
      3'b110:  h = HALF_32;
      3'b111:  h = HALF_64;
      default: h = HALF_4;
    endcase
    return h;
  endfunction

  function automatic logic [7:0] bit_rev8(input logic [7:0] d);
    logic [7:0] r;
    r = BYTE_ZERO;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7-i];
    end
    return r;
  endfunction

endpackage

`default_nettype wire

// File: hw/smsp_sync3.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input is asynchronous to hclk
// Notes:   output follows once stages two and three agree
`default_nettype none

module smsp_sync3 #(
  parameter logic INIT = 1'b0
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic clk_en,
  input  wire logic d,
  output var  logic q
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      q    <= INIT;
    end else if (clk_en) begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q <= s3_r;
      end
    end
  end

endmodule // smsp_sync3

`default_nettype wire

// File: hw/smsp_rate_div.sv
// Purpose: master serial clock half-period tick generator
// Assumes: run is high only while a master frame is in flight
// Notes:   counter held clear while idle so every frame starts aligned
`default_nettype none

module smsp_rate_div (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       clk_en,
  input  wire logic       run,
  input  wire logic       dbl,
  input  wire logic [1:0] rate,
  output logic            tick
);
  import smsp_pkg::*;

  logic [6:0] cnt_r;
  logic [6:0] half;

  assign half = half_cycles(dbl, rate);
  assign tick = run && (cnt_r == half - 7'h01);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 7'h00;
    end else if (clk_en) begin
      if (!run || tick) begin
        cnt_r <= 7'h00;
      end else begin
        cnt_r <= cnt_r + 7'h01;
      end
    end
  end

endmodule // smsp_rate_div

`default_nettype wire

// File: hw/smsp_top.sv
// Purpose: byte serial port, master or slave, behind an AHB-Lite slave
// Assumes: pin directions come from the port block as dir_* levels
// Notes:   zero-wait bus; pin inputs pass three-stage synchronisers
//
// The AHB-Lite interface to the registers is this design's own decision.
`default_nettype none

module smsp_top (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       clk_en,
  // ahb-lite slave
  input  wire logic                       hsel,
  input  wire logic [smsp_pkg::BUS_W-1:0] haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [smsp_pkg::BUS_W-1:0] hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic [smsp_pkg::BUS_W-1:0]      hrdata,
  // cpu side
  input  wire logic                       glob_irq_enable,
  input  wire logic                       irq_vector_ack,
  output logic                            port_irq,
  // pin directions set by software elsewhere
  input  wire logic                       dir_mosi_out,
  input  wire logic                       dir_miso_out,
  input  wire logic                       dir_sck_out,
  input  wire logic                       dir_ss_out,
  // pins
  input  wire logic                       sck_i,
  output logic                            sck_o,
  output logic                            sck_oe,
  input  wire logic                       mosi_i,
  output logic                            mosi_o,
  output logic                            mosi_oe,
  input  wire logic                       miso_i,
  output logic                            miso_o,
  output logic                            miso_oe,
  input  wire logic                       ss_n_i
);
  import smsp_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0]       ctrl_r;
  logic             dbl_r;
  logic             transfer_complete_flag_r;
  logic             write_collision_flag_r;
  logic             arm_transfer_complete_flag_r;
  logic             arm_write_collision_flag_r;
  logic [7:0]       rx_buf_r;
  logic [7:0]       sr_r;
  logic [7:0]       tx_r;
  logic             lat_r;
  logic [3:0]       cnt_r;
  smsp_state_t      state_r;
  logic             sck_r;
  logic             sck_prev_r;
  logic [BUS_W-1:0] hrdata_r;
  logic             dph_wr_r;
  logic [DEC_W-1:0] dph_addr_r;
  logic             sck_q, mosi_q, miso_q, ss_n_q, tick;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  smsp_sync3 #(.INIT(1'b0)) u_sync_sck (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .d       (sck_i),
    .q       (sck_q)
  );
  smsp_sync3 #(.INIT(1'b0)) u_sync_mosi (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .d       (mosi_i),
    .q       (mosi_q)
  );
  smsp_sync3 #(.INIT(1'b0)) u_sync_miso (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .d       (miso_i),
    .q       (miso_q)
  );
  smsp_sync3 #(.INIT(1'b1)) u_sync_ss (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .d       (ss_n_i),
    .q       (ss_n_q)
  );

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic a_go, a_rd, rd_stat, rd_data;
  logic wr_ctrl, wr_stat, wr_data, data_acc;
  assign hreadyout = clk_en;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  assign a_go    = hsel && htrans[1] && hready && clk_en;
  assign a_rd    = a_go && !hwrite;
  assign rd_stat = a_rd && (haddr[DEC_W-1:0] == ADDR_STAT);
  assign rd_data = a_rd && (haddr[DEC_W-1:0] == ADDR_DATA);
  assign wr_ctrl = dph_wr_r && (dph_addr_r == ADDR_CTRL);
  assign wr_stat = dph_wr_r && (dph_addr_r == ADDR_STAT);
  assign wr_data = dph_wr_r && (dph_addr_r == ADDR_DATA);
  assign data_acc = rd_data || wr_data;

  // ------------------------------------------------------------
  // port control
  // ------------------------------------------------------------
  logic       en, mst, clock_polarity, clock_phase, lsb, run, demote, s_act;
  logic       m_ev, s_ev, ev, lead, sample, din, last, busy;
  logic       load, start, shift_now, s_abort;
  logic [7:0] final_byte;
  assign en   = ctrl_r[C_PORT_EN];
  assign mst  = ctrl_r[C_MASTER_SELECT];
  assign clock_polarity = ctrl_r[C_CLOCK_POLARITY];
  assign clock_phase = ctrl_r[C_CLOCK_PHASE];
  assign lsb  = ctrl_r[C_LSB];
  assign run  = (state_r == ST_RUN);

  // in master role, select only counts as an input when not configured as output; slave role takes it whatever dir_ss_out says
  assign demote = en && mst && !dir_ss_out && !ss_n_q;
  assign s_act  = en && !mst && !ss_n_q;
  assign m_ev   = run && tick;
  assign s_ev   = s_act && (sck_q != sck_prev_r);
  assign ev     = m_ev || s_ev;
  // leading edge leaves the idle level
  assign lead   = mst ? (cnt_r[0] == 1'b0) : (sck_q != clock_polarity);
  assign sample = lead ^ clock_phase;
  assign din    = mst ? miso_q : mosi_q;
  assign last   = ev && (cnt_r == EDGE_LAST);
  assign busy   = run || (s_act && ((cnt_r != EDGE_ZERO) || s_ev));
  assign load   = wr_data && !busy;
  assign start  = load && en && mst && !demote;
  // phase 1 has no setup on the very first leading edge
  assign shift_now = ev && !sample &&
                     !(clock_phase && (cnt_r == EDGE_ZERO));
  assign s_abort = en && !mst && ss_n_q &&
                   (cnt_r != EDGE_ZERO);
  assign final_byte = clock_phase ? {sr_r[6:0], din} : {sr_r[6:0], lat_r};

  smsp_rate_div u_rate_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .run     (run),
    .dbl     (dbl_r),
    .rate    ({ctrl_r[C_RATE_HI], ctrl_r[C_RATE_LO]}),
    .tick    (tick)
  );

  // ------------------------------------------------------------
  // bus phase registers and read data
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_r   <= 1'b0;
      dph_addr_r <= '0;
      hrdata_r   <= '0;
    end else if (clk_en) begin
      dph_wr_r <= a_go && hwrite;
      if (a_go) begin
        dph_addr_r <= haddr[DEC_W-1:0];
      end
      if (a_rd) begin
        case (haddr[DEC_W-1:0])
          ADDR_CTRL: hrdata_r <= {24'h000000, ctrl_r};
          ADDR_STAT: hrdata_r <= {24'h000000, transfer_complete_flag_r, write_collision_flag_r,
                                  5'h00, dbl_r};
          ADDR_DATA: hrdata_r <= {24'h000000, rx_buf_r};
          default:   hrdata_r <= '0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // control and status registers
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RST;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_r <= hwdata[7:0];
      end
      // demotion wins over a same-cycle write, avoiding contention
      if (demote) begin
        ctrl_r[C_MASTER_SELECT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dbl_r <= 1'b0;
    end else if (clk_en && wr_stat) begin
      dbl_r <= hwdata[S_DBL];
    end
  end

  // ------------------------------------------------------------
  // flags: hardware set beats software clear
  // ------------------------------------------------------------
  logic transfer_complete_flag_clr, write_collision_flag_clr;

  assign transfer_complete_flag_clr = irq_vector_ack ||
                    (data_acc && (arm_transfer_complete_flag_r || arm_write_collision_flag_r));
  assign write_collision_flag_clr = data_acc && arm_write_collision_flag_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      transfer_complete_flag_r     <= 1'b0;
      write_collision_flag_r     <= 1'b0;
      arm_transfer_complete_flag_r <= 1'b0;
      arm_write_collision_flag_r <= 1'b0;
    end else if (clk_en) begin
      transfer_complete_flag_r <= last || demote || (transfer_complete_flag_r && !transfer_complete_flag_clr);
      write_collision_flag_r <= (wr_data && busy) || (write_collision_flag_r && !write_collision_flag_clr);
      if (rd_stat) begin
        arm_transfer_complete_flag_r <= transfer_complete_flag_r;
        arm_write_collision_flag_r <= write_collision_flag_r;
      end else if (data_acc) begin
        arm_transfer_complete_flag_r <= 1'b0;
        arm_write_collision_flag_r <= 1'b0;
      end
    end
  end

  // interrupt level; rechecking the master bit is software's job
  assign port_irq = transfer_complete_flag_r && ctrl_r[C_IRQ_EN] &&
                    glob_irq_enable;

  // ------------------------------------------------------------
  // master sequencer and serial clock
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
    end else if (clk_en) begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!en || demote || !mst || last) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_r <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        sck_r <= clock_polarity;
      end else if (tick) begin
        sck_r <= !sck_r;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_prev_r <= 1'b0;
    end else if (clk_en) begin
      sck_prev_r <= s_act ? sck_q : clock_polarity;
    end
  end

  // ------------------------------------------------------------
  // shifter, edge count and receive buffer
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= EDGE_ZERO;
      lat_r <= 1'b0;
    end else if (clk_en) begin
      if (!en || demote || s_abort || last || start) begin
        cnt_r <= EDGE_ZERO;
      end else if (ev) begin
        cnt_r <= cnt_r + 4'h1;
      end
      if (ev && sample) begin
        lat_r <= din;
      end
    end
  end

  // byte kept reversed for lsb-first so the wire bit is always bit 7
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sr_r     <= BYTE_ZERO;
      tx_r     <= BYTE_ZERO;
      rx_buf_r <= BYTE_ZERO;
    end else if (clk_en) begin
      if (load) begin
        sr_r <= lsb ? bit_rev8(hwdata[7:0]) : hwdata[7:0];
        tx_r <= lsb ? bit_rev8(hwdata[7:0]) : hwdata[7:0];
      end else if (s_abort) begin
        sr_r <= tx_r;
      end else if (last) begin
        sr_r     <= final_byte;
        rx_buf_r <= lsb ? bit_rev8(final_byte) : final_byte;
      end else if (shift_now) begin
        sr_r <= {sr_r[6:0], lat_r};
      end
    end
  end

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  assign sck_o   = sck_r;
  assign mosi_o  = sr_r[7];
  assign miso_o  = sr_r[7];
  assign sck_oe  = en && mst && dir_sck_out;
  assign mosi_oe = en && mst && dir_mosi_out;
  assign miso_oe = s_act && dir_miso_out;

endmodule // smsp_top

`default_nettype wire

// File: sim/smsp_checker.sv
// Purpose: timing checks on the serial port's bus and pin ports
// Assumes: zero-wait single transfers, one clock domain
// Notes:   control bits are shadowed from the writes seen on the bus
`default_nettype none

module smsp_checker (
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire logic                       clk_en,
  input wire logic                       hsel,
  input wire logic [smsp_pkg::BUS_W-1:0] haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic [smsp_pkg::BUS_W-1:0] hwdata,
  input wire logic                       hready,
  input wire logic                       glob_irq_enable,
  input wire logic                       port_irq,
  input wire logic                       dir_sck_out,
  input wire logic                       dir_miso_out,
  input wire logic                       dir_ss_out,
  input wire logic                       ss_n_i,
  input wire logic                       sck_o,
  input wire logic                       sck_oe,
  input wire logic                       mosi_oe,
  input wire logic                       miso_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  import smsp_pkg::*;

  logic       dp_wr, clock_polarity_s, ie_s, en_s, sck_q;
  logic [9:0] dp_a;
  logic [4:0] edg_r;
  wire logic  ctrl_wr = dp_wr && dp_a == ADDR_CTRL;
  wire logic  data_wr = dp_wr && dp_a == ADDR_DATA;

  // edge count restarts on any data or control write, so a
  // collision write shortens the count and can never inflate it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {dp_wr, clock_polarity_s, ie_s, en_s, sck_q} <= '0;
      dp_a  <= '0;
      edg_r <= '0;
    end else begin
      dp_wr <= hsel && htrans[1] && hready && hwrite && clk_en;
      dp_a  <= haddr[9:0];
      sck_q <= sck_o;
      if (ctrl_wr) begin
        {ie_s, en_s, clock_polarity_s} <= {hwdata[7], hwdata[6], hwdata[3]};
      end
      if (ctrl_wr || data_wr) begin
        edg_r <= '0;
      end else if (sck_o != sck_q) begin
        edg_r <= edg_r + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_outside_select;
    (!dir_ss_out && !ss_n_i && en_s) [*6];
  endsequence

  a_irq_gated: assert property (
    port_irq |-> ie_s && glob_irq_enable)
    else $error("port irq without both enables");
  a_idle_level: assert property (
    ctrl_wr && hwdata[6] && hwdata[4] |-> ##3 (sck_o == clock_polarity_s))
    else $error("serial clock not at idle polarity");
  a_off_no_clock: assert property (
    !en_s && !ctrl_wr && !$past(ctrl_wr) |=> $stable(sck_o))
    else $error("serial clock moved while disabled");
  a_frame_full: assert property (
    $rose(port_irq) |-> ##[0:2] (edg_r == 5'h10))
    else $error("frame did not have sixteen clock edges");
  a_frame_max: assert property (edg_r <= 5'h10)
    else $error("more than sixteen clock edges in a frame");
  a_sck_dir: assert property (sck_oe |-> dir_sck_out && en_s)
    else $error("clock driven without enable or direction");
  a_miso_dir: assert property (miso_oe |-> dir_miso_out)
    else $error("slave data out driven while set as input");
  a_demote_release: assert property (
    s_outside_select |-> !sck_oe && !mosi_oe)
    else $error("pins still driven after outside select");
endmodule // smsp_checker

bind smsp_top smsp_checker u_chk (
  .hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .glob_irq_enable, .port_irq, .dir_sck_out, .dir_miso_out,
  .dir_ss_out, .ss_n_i, .sck_o, .sck_oe, .mosi_oe, .miso_oe
);

`default_nettype wire

// File: sim/smsp_slave_model.sv
// Purpose: behavioural serial slave facing the port in master role
// Assumes: mode bits settle before select falls
// Notes:   a released data line shows the inverse of its last bit
`default_nettype none

module smsp_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  input  wire logic       clock_polarity,
  input  wire logic       clock_phase,
  input  wire logic       lsb,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] sh;
  logic       first;
  wire logic  mosi_h;

  // sample the line as it stood just before the clock edge
  assign #1 mosi_h = mosi;

  initial begin
    {miso, first} = 2'b00;
    rx = 8'h00;
    sh = 8'h00;
  end

  always @(negedge ss_n) begin
    sh    = tx;
    first = clock_phase;
    miso  = lsb ? tx[0] : tx[7];
  end

  always @(posedge ss_n) miso = ~miso;

  // leading edge leaves the idle level; sample edge swaps with phase
  always @(sck) begin
    if (!ss_n && ((sck != clock_polarity) ^ clock_phase)) begin
      rx = lsb ? {mosi_h, rx[7:1]} : {rx[6:0], mosi_h};
    end else if (!ss_n) begin
      if (!first) sh = lsb ? sh >> 1 : sh << 1;
      first = 1'b0;
      miso  = lsb ? sh[0] : sh[7];
    end
  end
endmodule // smsp_slave_model

`default_nettype wire

// File: sim/smsp_top_test.sv
// Purpose: register-level tests of the serial port in master role, plus one slave-role byte
// Assumes: zero-wait bus, slave model on the far side
// Notes:   frame time is found by status polling, a few cycles coarse
`default_nettype none

module smsp_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import smsp_pkg::*;

  logic        hclk, hresetn, hsel, hwrite, glob, ack, ss_n, m_sck, m_mosi;
  logic        dir_ss, dir_miso, hreadyout, hresp, port_irq, s_miso;
  logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  s_tx, s_rx, ctl;
  int          bad_count, checked, now_c;
  int          div [8] = '{4, 16, 64, 128, 2, 8, 32, 64};

  smsp_top uut (
    .hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .glob_irq_enable(glob), .irq_vector_ack(ack), .port_irq,
    .dir_mosi_out(1'b1), .dir_miso_out(dir_miso), .dir_sck_out(1'b1),
    .dir_ss_out(dir_ss), .sck_i(sck_oe ? sck_o : m_sck), .sck_o,
    .sck_oe, .mosi_i(mosi_oe ? mosi_o : m_mosi), .mosi_o, .mosi_oe,
    .miso_i(s_miso), .miso_o, .miso_oe, .ss_n_i(ss_n)
  );

  smsp_slave_model peer (
    .sck(sck_o), .mosi(mosi_o), .ss_n, .clock_polarity(ctl[3]), .clock_phase(ctl[2]),
    .lsb(ctl[5]), .tx(s_tx), .miso(s_miso), .rx(s_rx)
  );

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  always @(posedge hclk) now_c <= now_c + 1;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out;
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic bus(input logic w, input logic [9:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {22'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] q;
    if (a == ADDR_CTRL) ctl <= d;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [9:0] a, output logic [31:0] q);
    bus(1'b0, a, 8'h00, q);
  endtask

  task automatic xfer(input logic [7:0] c, d, s, input logic full,
                      output int t);
    logic [31:0] q;
    int          t0;
    wr(ADDR_CTRL, c);
    s_tx <= s;
    // let the clock settle at its new idle level before selecting
    repeat (2) @(posedge hclk);
    ss_n <= 1'b0;
    wr(ADDR_DATA, d);
    t0 = now_c;
    q  = '0;
    for (int i = 0; i < 500 && q[7] !== 1'b1; i++) rd(ADDR_STAT, q);
    t = now_c - t0;
    chk("stat done", q[7:6], 2'b10);
    rd(ADDR_DATA, q);
    if (full) chk("rx byte", q, s);
    if (full) chk("tx byte", s_rx, d);
    rd(ADDR_STAT, q);
    chk("stat clear", q[7], 1'b0);
    rd(ADDR_CTRL, q);
    chk("ctrl kept", q, c);
    ss_n <= 1'b1;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    int          t;
    {hresetn, hsel, hwrite, glob, ack, dir_miso, m_sck, m_mosi} = '0;
    {ss_n, dir_ss} = 2'b11;
    {htrans, haddr, hwdata, s_tx, ctl} = '0;
    {bad_count, checked, now_c} = '0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ADDR_CTRL, q);
    chk("ctrl reset", q, 32'h0);
    rd(ADDR_STAT, q);
    chk("stat reset", q, 32'h0);
    rd(10'h3fc, q);
    chk("unmapped", q, 32'h0);
    // disabled port: a data write must not start a frame
    wr(ADDR_CTRL, 8'h10);
    wr(ADDR_DATA, 8'h55);
    repeat (200) @(posedge hclk);
    rd(ADDR_STAT, q);
    chk("off stat", q, 32'h0);
    for (int m = 0; m < 4; m++) begin
      xfer({2'b01, m[1] ^ m[0], 1'b1, m[1:0], 2'b01},
           8'h1e + 8'(m * 51), 8'hc4 - 8'(m), 1'b1, t);
    end
    for (int r = 0; r < 8; r++) begin
      wr(ADDR_STAT, {7'h0, r[2]});
      xfer({6'h14, r[1:0]}, 8'h5a, 8'h00, 1'b0, t);
      chk("frame len", t >= 8 * div[r] && t <= 8 * div[r] + 16, 1'b1);
    end
    wr(ADDR_STAT, 8'h00);
    // second write lands while the first byte is still shifting
    wr(ADDR_CTRL, 8'h51);
    wr(ADDR_DATA, 8'h0f);
    wr(ADDR_DATA, 8'hf0);
    repeat (160) @(posedge hclk);
    rd(ADDR_STAT, q);
    chk("collide", q, 32'hc0);
    rd(ADDR_DATA, q);
    rd(ADDR_STAT, q);
    chk("collide clr", q, 32'h0);
    glob <= 1'b1;
    wr(ADDR_CTRL, 8'hd1);
    wr(ADDR_DATA, 8'h33);
    for (int i = 0; i < 400 && port_irq !== 1'b1; i++) @(posedge hclk);
    chk("irq on", port_irq, 1'b1);
    glob <= 1'b0;
    @(posedge hclk);
    chk("irq global", port_irq, 1'b0);
    glob <= 1'b1;
    ack  <= 1'b1;
    @(posedge hclk);
    ack  <= 1'b0;
    @(posedge hclk);
    chk("irq ack", port_irq, 1'b0);
    // select as input pulled low by another master
    wr(ADDR_CTRL, 8'h51);
    dir_ss   <= 1'b0;
    dir_miso <= 1'b1;
    ss_n     <= 1'b0;
    repeat (10) @(posedge hclk);
    rd(ADDR_CTRL, q);
    chk("demoted", q, 32'h41);
    rd(ADDR_STAT, q);
    chk("demote flag", q[7], 1'b1);
    rd(ADDR_DATA, q);
    ss_n   <= 1'b1;
    dir_ss <= 1'b1;
    wr(ADDR_CTRL, 8'h51);
    rd(ADDR_CTRL, q);
    chk("remaster", q, 32'h51);
    // slave role, mode 0: the bench clocks one byte in on the pins
    wr(ADDR_CTRL, 8'h40);
    ss_n <= 1'b0;
    for (int b = 7; b >= 0; b--) begin
      m_mosi <= b[0];
      repeat (6) @(posedge hclk);
      m_sck <= 1'b1;
      repeat (6) @(posedge hclk);
      m_sck <= 1'b0;
    end
    repeat (6) @(posedge hclk);
    rd(ADDR_STAT, q);
    chk("slave done", q[7], 1'b1);
    rd(ADDR_DATA, q);
    chk("slave rx", q, 32'haa);
    ss_n <= 1'b1;
    close_out;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    close_out;
  end
endmodule // smsp_top_test

`default_nettype wire
